/* File: inc/tif_defines.vh */
`ifndef TIF_DEFINES_VH
`define TIF_DEFINES_VH

// register byte offsets
`define TIF_REG_CONTROL 12'h000
`define TIF_REG_STATUS 12'h004
`define TIF_REG_LAST 12'h008

// control field positions
`define TIF_CTL_FIFO_BYPASS_N 0
`define TIF_CTL_ENCODER_BYPASS_N 1
`define TIF_CTL_WIDTH_SELECT 2

// control reset value: fifo and encoder on, 8-bit characters
`define TIF_CTL_RESET 3'h7

// status field positions
`define TIF_ST_INT_LEVEL 0
`define TIF_ST_INT_PENDING 1
`define TIF_ST_HALTED 2
`define TIF_ST_CHAR_COUNT 8

// special and exception characters (low byte, with a special flag, or a violation flag for C0.7)
`define TIF_K28_0 8'h1C
`define TIF_K28_3 8'h7C
`define TIF_K28_5 8'hBC
`define TIF_C0_7 8'hE0

// synchroniser pin positions
`define TIF_PIN_INT 8
`define TIF_PIN_HALT_N 9
`define TIF_PIN_VIOL 10
`define TIF_PIN_CELL 11
`define TIF_PIN_SPECIAL 12
`define TIF_PIN_WEN 13
`define TIF_PIN_HCLK 14
`define TIF_PIN_RCLK 15
`define TIF_PIN_COUNT 16

`endif

/* File: rtl/tif_formatter.v */
// What this block does
// - host puts the character on the low eight bus bits, 8- or 10-bit wide
// - inputs are taken on host write clock or reference clock edge by path
// - encoder bypassed: low eight bits form low byte of raw character
// - interrupt input raises specials only with fifo and encoder both enabled
// - interrupt level change injects one special ahead of next fifo entry
// - rising change sends K28.0, falling change sends K28.3
// - fifo bypassed, encoder on: interrupt, halt and cell start ignored
// - fifo and encoder bypassed: interrupt pin is raw bit nine
// - fifo and encoder on: halt low stops fifo reads and sends K28.5; writes still go on
// - encoder bypassed: halt pin is always raw bit ten
// - fifo and encoder on: violation, cell start, special jointly chosen
// - fifo bypassed, encoder on, with violation set: send C0.7 instead of the data
// - encoder bypassed, 10-bit width: violation pin is raw bit eleven
// - encoder bypassed, 8-bit width: violation and cell start ignored
// - encoder bypassed, 10-bit width: cell start pin is raw bit twelve
// - fifo on with write enable: one fifo write per host clock edge
// - fifo bypassed without write enable: bus ignored, K28.5 sent
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "tif_defines.vh"

module tif_formatter
(
  // clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // host pins, asynchronous to clock_i
  input wire [7:0] tx_char_bus_i,
  input wire tx_interrupt_in_i,
  input wire tx_halt_n_i,
  input wire tx_violation_req_i,
  input wire tx_cell_start_i,
  input wire tx_special_select_i,
  input wire tx_write_enable_i,
  input wire host_write_clock_i,
  input wire reference_clock_i,
  // transmit fifo, same clock
  input wire [11:0] fifo_rdata_i,
  input wire fifo_empty_i,
  output reg fifo_wr_o,
  output reg [11:0] fifo_wdata_o,
  output reg fifo_rd_o,
  // formatted character towards encoder and shifter
  output reg char_valid_o,
  output reg [11:0] char_o,
  output reg char_special_o,
  output reg char_violation_o,
  output reg char_cell_o,
  output reg char_raw_o
);

  // configuration and state
  reg [2:0] control;
  reg [`TIF_PIN_COUNT-1:0] pin_meta;
  reg [`TIF_PIN_COUNT-1:0] pin_sync;
  reg hclk_prev;
  reg rclk_prev;
  reg int_prev;
  reg int_pending;
  reg [7:0] int_code;
  reg [15:0] char_count;
  reg [31:0] next_prdata;
  reg next_pslverr;
  reg [11:0] raw_char;

  wire fifo_on = control[`TIF_CTL_FIFO_BYPASS_N];
  wire enc_on = control[`TIF_CTL_ENCODER_BYPASS_N];
  wire width8 = control[`TIF_CTL_WIDTH_SELECT];
  wire hclk_edge = pin_sync[`TIF_PIN_HCLK] & ~hclk_prev;
  wire rclk_edge = pin_sync[`TIF_PIN_RCLK] & ~rclk_prev;
  wire s_int = pin_sync[`TIF_PIN_INT];
  wire s_halt_n = pin_sync[`TIF_PIN_HALT_N];
  wire s_viol = pin_sync[`TIF_PIN_VIOL];
  wire s_cell = pin_sync[`TIF_PIN_CELL];
  wire s_special = pin_sync[`TIF_PIN_SPECIAL];
  wire s_wen = pin_sync[`TIF_PIN_WEN];
  wire full_mode = fifo_on & enc_on;
  // fifo path writes on the host clock, bypass path uses the reference
  wire host_sample = fifo_on & hclk_edge;
  wire ref_sample = rclk_edge;
  wire int_change = full_mode & (s_int != int_prev);
  wire apb_access = psel_i & penable_i & ~pready_o;
  wire apb_done = psel_i & penable_i & pready_o;

  // two-stage synchroniser for every host pin
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_meta <= {`TIF_PIN_COUNT{1'b0}};
      pin_sync <= {`TIF_PIN_COUNT{1'b0}};
      hclk_prev <= 1'b0;
      rclk_prev <= 1'b0;
    end
    else
    begin
      pin_meta <= {reference_clock_i, host_write_clock_i, tx_write_enable_i,
                   tx_special_select_i, tx_cell_start_i, tx_violation_req_i,
                   tx_halt_n_i, tx_interrupt_in_i, tx_char_bus_i};
      pin_sync <= pin_meta;
      hclk_prev <= pin_sync[`TIF_PIN_HCLK];
      rclk_prev <= pin_sync[`TIF_PIN_RCLK];
    end
  end

  // raw character assembly when the encoder is bypassed
  always @*
  begin
    raw_char = 12'h000;
    raw_char[7:0] = pin_sync[7:0];
    raw_char[8] = s_int;
    raw_char[9] = s_halt_n;
    if (!width8)
    begin
      raw_char[10] = s_viol;
      raw_char[11] = s_cell;
    end
    // 8-bit width leaves violation and cell start unused
  end

  // fifo writes on each host clock edge while write enable is high
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fifo_wr_o <= 1'b0;
      fifo_wdata_o <= 12'h000;
    end
    else
    begin
      fifo_wr_o <= host_sample & s_wen;
      if (host_sample & s_wen)
      begin
        if (enc_on)
          fifo_wdata_o <= {s_cell, s_viol, s_special, 1'b0,
                           pin_sync[7:0]};
        else
          fifo_wdata_o <= raw_char;
      end
    end
  end

  // interrupt edge tracking, sampled with the fifo writes
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      int_prev <= 1'b0;
      int_pending <= 1'b0;
      int_code <= 8'h00;
    end
    else
    begin
      if (host_sample & int_change)
      begin
        int_prev <= s_int;
        int_pending <= 1'b1;
        int_code <= s_int ? `TIF_K28_0 : `TIF_K28_3;
      end
      else if (ref_sample & full_mode & int_pending)
        int_pending <= 1'b0;
      else if (!full_mode)
        int_pending <= 1'b0;
    end
  end

  // character slot on each reference clock edge
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      char_valid_o <= 1'b0;
      char_o <= 12'h000;
      char_special_o <= 1'b0;
      char_violation_o <= 1'b0;
      char_cell_o <= 1'b0;
      char_raw_o <= 1'b0;
      fifo_rd_o <= 1'b0;
      char_count <= 16'h0000;
    end
    else
    begin
      char_valid_o <= ref_sample;
      fifo_rd_o <= 1'b0;
      if (ref_sample)
      begin
        char_count <= char_count + 16'h0001;
        char_violation_o <= 1'b0;
        char_cell_o <= 1'b0;
        char_raw_o <= ~enc_on;
        char_special_o <= 1'b0;
        if (fifo_on)
        begin
          if (full_mode & int_pending)
          begin
            // interrupt special bypasses the fifo
            char_o <= {4'h0, int_code};
            char_special_o <= 1'b1;
          end
          else if ((full_mode & ~s_halt_n) | fifo_empty_i)
          begin
            // halted or empty: idle, reads stopped
            char_o <= enc_on ? {4'h0, `TIF_K28_5} : 12'h000;
            char_special_o <= enc_on;
          end
          else if (enc_on)
          begin
            fifo_rd_o <= 1'b1;
            char_cell_o <= fifo_rdata_i[11];
            if (fifo_rdata_i[10])
            begin
              char_o <= {4'h0, `TIF_C0_7};
              char_violation_o <= 1'b1;
            end
            else
            begin
              char_o <= {4'h0, fifo_rdata_i[7:0]};
              char_special_o <= fifo_rdata_i[9];
            end
          end
          else
          begin
            fifo_rd_o <= 1'b1;
            char_o <= fifo_rdata_i;
          end
        end
        else if (!s_wen)
        begin
          // bus ignored, sync characters sent
          char_o <= {4'h0, `TIF_K28_5};
          char_special_o <= 1'b1;
          char_raw_o <= 1'b0;
        end
        else if (enc_on & s_viol)
        begin
          char_o <= {4'h0, `TIF_C0_7};
          char_violation_o <= 1'b1;
        end
        else if (enc_on)
        begin
          // interrupt, halt and cell start unused here
          char_o <= {4'h0, pin_sync[7:0]};
          char_special_o <= s_special;
        end
        else
          char_o <= raw_char;
      end
    end
  end

  // apb read mux and decode
  always @*
  begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    case (paddr_i)
      `TIF_REG_CONTROL:
        next_prdata = {29'h0000_0000, control};
      `TIF_REG_STATUS:
      begin
        next_prdata[`TIF_ST_INT_LEVEL] = int_prev;
        next_prdata[`TIF_ST_INT_PENDING] = int_pending;
        next_prdata[`TIF_ST_HALTED] = full_mode & ~s_halt_n;
        next_prdata[`TIF_ST_CHAR_COUNT+15:`TIF_ST_CHAR_COUNT] = char_count;
      end
      `TIF_REG_LAST:
        next_prdata = {16'h0000, char_raw_o, char_cell_o, char_violation_o,
                       char_special_o, char_o};
      default:
        next_pslverr = 1'b1;
    endcase
  end

  // apb slave: answers one cycle into the access phase
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
      control <= `TIF_CTL_RESET;
    end
    else
    begin
      pready_o <= apb_access;
      if (apb_access)
      begin
        prdata_o <= pwrite_i ? 32'h0000_0000 : next_prdata;
        pslverr_o <= next_pslverr;
      end
      else
      begin
        prdata_o <= 32'h0000_0000;
        pslverr_o <= 1'b0;
      end
      if (apb_done & pwrite_i & (paddr_i == `TIF_REG_CONTROL))
        control <= pwdata_i[2:0];
    end
  end

endmodule // tif_formatter

/* File: verification/tif_monitor.sv */
`timescale 1ns/1ns
module tif_monitor
(
  // clock, reset and apb
  input wire clock_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire pready_o,
  input wire pslverr_o,
  // pins and results
  input wire tx_halt_n_i,
  input wire fifo_wr_o,
  input wire fifo_rd_o,
  input wire char_valid_o,
  input wire [11:0] char_o,
  input wire char_special_o,
  input wire char_violation_o,
  input wire char_raw_o
);
  reg [2:0] ctl;
  reg [3:0] age;
  wire ok = age == 4'hF;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // shadow control word, aged so a mode change settles first
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ctl <= 3'h7;
    else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == 0)
      ctl <= pwdata_i[2:0];
  end
  // settle counter restarts on every apb access
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      age <= 4'h0;
    else if (psel_i)
      age <= 4'h0;
    else if (!ok)
      age <= age + 4'h1;
  end
  sequence s_access;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence s_halted;
    !tx_halt_n_i [*8];
  endsequence
  AST_APB_WAIT: assert property (s_access |=> pready_o ##1 !pready_o)
    else $error("apb answer not one wait state");
  AST_ERR_PAIR: assert property (pslverr_o |-> pready_o)
    else $error("slave error without ready");
  AST_WR_GATE: assert property (fifo_wr_o && ok |-> ctl[0])
    else $error("fifo write while fifo bypassed");
  AST_WR_ONE: assert property (fifo_wr_o |=> !fifo_wr_o [*7])
    else $error("more than one fifo write per host edge");
  AST_SLOT: assert property (char_valid_o |=> !char_valid_o [*7])
    else $error("more than one slot per reference edge");
  AST_RD_GATE: assert property (
    fifo_rd_o && ok |-> ctl[0] && char_valid_o)
    else $error("fifo read outside a fifo slot");
  AST_RAW_FLAG: assert property (
    char_valid_o && ok |-> char_raw_o == !ctl[1])
    else $error("raw flag does not follow encoder bypass");
  AST_NARROW: assert property (
    char_valid_o && ok && ctl[2:1] == 2'b10 |-> char_o[11:10] == 2'b00)
    else $error("8-bit raw character has upper bits");
  AST_VIOL: assert property (
    char_valid_o && char_violation_o && !char_raw_o |-> char_o[7:0] == 8'hE0)
    else $error("violation slot is not the exception code");
  AST_HALT: assert property (
    s_halted ##0 char_valid_o && ok && ctl[1:0] == 2'b11
    |-> !fifo_rd_o && char_special_o && char_o[7:0] == 8'hBC)
    else $error("halted slot read fifo or sent no idle");
endmodule // tif_monitor

bind tif_formatter tif_monitor tif_monitor_i (
  .clock_i(clock_i),
  .rst_n_i(rst_n_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .tx_halt_n_i(tx_halt_n_i),
  .fifo_wr_o(fifo_wr_o),
  .fifo_rd_o(fifo_rd_o),
  .char_valid_o(char_valid_o),
  .char_o(char_o),
  .char_special_o(char_special_o),
  .char_violation_o(char_violation_o),
  .char_raw_o(char_raw_o)
);

/* File: verification/tif_host_model.sv */
`timescale 1ns/1ns
module tif_host_model
(
  // system clock and requested pin levels
  input wire clock_i,
  input wire [13:0] req_i,
  // pins towards the block
  output reg [13:0] pins_o = 14'h0200,
  output wire hclk_o,
  output wire rclk_o
);
  reg [2:0] cnt = 3'h0;
  // both clocks share one 8-cycle period
  assign hclk_o = cnt[2];
  assign rclk_o = cnt[2];
  // pins move while clocks are high, clear of both rising edges
  always @(posedge clock_i)
  begin
    cnt <= cnt + 3'h1;
    if (cnt == 3'h6)
      pins_o <= req_i;
  end
endmodule // tif_host_model

/* File: verification/tif_formatter_bench.sv */
`timescale 1ns/1ns
module tif_formatter_bench;
  reg clock_i = 0;
  reg rst_n_i = 0;
  reg psel_i = 0;
  reg penable_i = 0;
  reg pwrite_i = 0;
  reg [11:0] paddr_i = 0;
  reg [31:0] pwdata_i = 0;
  reg [11:0] fifo_rdata_i = 12'h05A;
  reg fifo_empty_i = 1;
  reg [13:0] req = 14'h0200;
  reg [31:0] rd;
  reg err;
  integer n_mismatch = 0, n_checks = 0, i, bad, wd;
  wire [7:0] tx_char_bus_i;
  wire tx_interrupt_in_i, tx_halt_n_i, tx_violation_req_i, tx_cell_start_i;
  wire tx_special_select_i, tx_write_enable_i;
  wire host_write_clock_i, reference_clock_i;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, fifo_wr_o, fifo_rd_o, char_valid_o;
  wire [11:0] fifo_wdata_o, char_o;
  wire char_special_o, char_violation_o, char_cell_o, char_raw_o;
  always #2 clock_i = ~clock_i;
  tif_host_model tif_host_model_i (.clock_i(clock_i), .req_i(req),
    .pins_o({tx_write_enable_i, tx_special_select_i, tx_cell_start_i,
    tx_violation_req_i, tx_halt_n_i, tx_interrupt_in_i, tx_char_bus_i}),
    .hclk_o(host_write_clock_i), .rclk_o(reference_clock_i));
  tif_formatter tif_formatter_i (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .tx_char_bus_i(tx_char_bus_i),
    .tx_interrupt_in_i(tx_interrupt_in_i),
    .tx_halt_n_i(tx_halt_n_i),
    .tx_violation_req_i(tx_violation_req_i),
    .tx_cell_start_i(tx_cell_start_i),
    .tx_special_select_i(tx_special_select_i),
    .tx_write_enable_i(tx_write_enable_i),
    .host_write_clock_i(host_write_clock_i),
    .reference_clock_i(reference_clock_i),
    .fifo_rdata_i(fifo_rdata_i),
    .fifo_empty_i(fifo_empty_i),
    .fifo_wr_o(fifo_wr_o),
    .fifo_wdata_o(fifo_wdata_o),
    .fifo_rd_o(fifo_rd_o),
    .char_valid_o(char_valid_o),
    .char_o(char_o),
    .char_special_o(char_special_o),
    .char_violation_o(char_violation_o),
    .char_cell_o(char_cell_o),
    .char_raw_o(char_raw_o)
  );
  task chk(input [79:0] nm, input [31:0] exp, input [31:0] got);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0s expected %h seen %h", nm, exp, got);
    end
  end
  endtask
  // waits a bounded span for a slot matching the masked value
  task slot(input [79:0] nm, input [12:0] m, input [12:0] e);
    reg [12:0] v;
  begin
    v = ~e;
    for (i = 0; i < 80 && v !== e; i = i + 1)
    begin
      @(posedge clock_i);
      if (char_valid_o === 1'b1)
        v = {char_special_o, char_o} & m;
    end
    chk(nm, {19'h0, e}, {19'h0, v});
  end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
  begin
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    @(posedge clock_i);
    while (pready_o !== 1'b1)
      @(posedge clock_i);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  end
  endtask
  task t_regs;
  begin
    apb(0, 12'h000, 0);
    chk("control", 32'h0000_0007, rd);
    apb(1, 12'h00C, 32'hFFFF_FFFF);
    apb(0, 12'h00C, 0);
    chk("unmapped", 32'h0000_0001, {rd[30:0], err});
    $display("test regs done");
  end
  endtask
  task t_int;
  begin
    req <= 14'h0300;
    slot("int rise", 13'h10FF, 13'h101C);
    req <= 14'h0200;
    slot("int fall", 13'h10FF, 13'h107C);
    $display("test interrupt done");
  end
  endtask
  task t_halt;
  begin
    req <= 14'h283C;
    repeat (16) @(posedge clock_i);
    fifo_empty_i <= 1'b0;
    bad = 0;
    wd = 0;
    for (i = 0; i < 64; i = i + 1)
    begin
      @(posedge clock_i);
      if (fifo_rd_o === 1'b1 || char_valid_o && char_o[7:0] !== 8'hBC)
        bad = bad + 1;
      if (fifo_wr_o === 1'b1)
        wd = {fifo_wdata_o[11:9], fifo_wdata_o[7:0]};
    end
    chk("halt", 0, bad);
    chk("fifo data", 32'h0000_043C, wd);
    // halted flag in status while the halt pin is low
    apb(0, 12'h004, 0);
    chk("status", 32'h0000_0004, rd & 32'h0000_0007);
    req <= 14'h0200;
    slot("resume", 13'h10FF, 13'h005A);
    // fifo entry with violation and special set: violation wins
    fifo_rdata_i <= 12'h65A;
    slot("fifo viol", 13'h10FF, 13'h00E0);
    chk("viol flag", 1, char_violation_o);
    fifo_empty_i <= 1'b1;
    $display("test halt done");
  end
  endtask
  task t_bypass;
  begin
    // cell start pin set too: it must not reach the slot
    req <= 14'h2D11;
    apb(1, 12'h000, 32'h0000_0002);
    slot("violation", 13'h00FF, 13'h00E0);
    chk("cell pin", 0, char_cell_o);
    req <= 14'h0000;
    slot("sync idle", 13'h10FF, 13'h10BC);
    $display("test bypass done");
  end
  endtask
  task t_raw;
  begin
    // write enable high, else the bypassed path sends sync characters
    req <= 14'h2BA5;
    apb(1, 12'h000, 32'h0000_0000);
    slot("raw 12", 13'h0FFF, 13'h0BA5);
    apb(1, 12'h000, 32'h0000_0004);
    slot("raw 10", 13'h0FFF, 13'h03A5);
    // last slot word: raw flag set, no cell, violation or special
    apb(0, 12'h008, 0);
    chk("last", 32'h0000_83A5, rd);
    $display("test raw done");
  end
  endtask
  task results;
  begin
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  initial
  begin
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_int;
    t_halt;
    t_bypass;
    t_raw;
    results;
  end
  // watchdog well beyond the expected run
  initial
  begin
    #200000;
    n_mismatch = n_mismatch + 1;
    results;
  end
endmodule // tif_formatter_bench
